// ===== verilog/standby_clock_mode_control.sv
// standby, oscillator and main clock mode control with its two control registers
// Operation
// - machine cycle lasts four high-frequency clock periods in single clock mode.
// - after any reset start in NORMAL mode, everything on the fast clock.
// - timing generator is 3-stage prescaler, 21-stage divider and machine cycle counter.
// - prescaler and divider cleared on reset, STOP entry and STOP exit.
// - writing one to bit 7 of the stop control register enters STOP.
// - STOP halts oscillator and internal circuits, all state kept except the timing generator, which is held at zero.
// - while stopped the CPU is held so its program counter does not move.
// - wake method bit 0 wakes on rising edge, 1 on high level.
// - level method with pin high skips STOP and goes straight to warm-up.
// - after warm-up execution resumes at the instruction after the STOP request.
// - warm-up field picks 3x2^16, 2^16 or 2^14 clocks, doubled by divider select.
// - port hold bit 0 floats port outputs in STOP, 1 holds them.
// - leaving STOP clears the STOP request bit in hardware.
// - reset pin wake always lands in NORMAL regardless of return mode.
// - bits 1 and 0 of the stop control register read undefined.
// - oscillator enable 0 stops the oscillator and resets the device.
// - IDLE bit stops CPU and watchdog, peripherals keep running.
// - enabled interrupt ends IDLE; master flag picks service first or next instruction.
// - leaving STOP with return mode 0 sets oscillator enable 1, clock select 0.
// - external interrupt pin change during STOP or warm-up sets its latch.
// - during warm-up only the oscillator runs, internal circuits stay idle; here the timing generator keeps counting through warm-up.
`timescale 1ns/10ps
module standby_clock_mode_control #(
  parameter int N_INT = 6,
  parameter int WARMUP_LONG = 196608,
  parameter int WARMUP_MID = 65536,
  parameter int WARMUP_SHORT = 16384
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // core register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // pins
  input wire logic i_stop_pin,
  input wire logic [N_INT-1:0] i_ext_int,
  // core status inputs
  input wire logic i_divider_input_select,
  input wire logic i_irq_wake,
  input wire logic i_master_interrupt_flag,
  // timing generator outputs
  output logic o_mcycle_stb,
  output logic [standby_pkg::DIV_W-1:0] o_timebase,
  // mode and clock control outputs
  output logic [3:0] o_mode,
  output logic o_osc_enable,
  output logic o_main_clock_select,
  output logic o_cpu_run,
  output logic o_wdt_run,
  output logic o_periph_run,
  output logic o_port_hiz,
  output logic o_sys_reset,
  // interrupt side outputs
  output logic [N_INT-1:0] o_ext_int_set,
  output logic o_wake_to_isr,
  output logic o_wake_to_next
);
  import standby_pkg::*;

  if (2 * WARMUP_LONG >= 2 ** WU_W || 2 * WARMUP_MID >= 2 ** WU_W || WARMUP_SHORT < 1 || N_INT < 1) begin : g_bad_params
    $error("warm-up counts do not fit the warm-up counter");
  end

  standby_if #(.N_INT(N_INT)) sif ();

  mode_t state_r;
  logic [7:0] stop_ctrl_r;
  logic [7:0] osc_ctrl_r;
  logic [WU_W-1:0] wu_cnt_r;
  logic soft_rst_r;
  logic [7:0] rdata_r;
  logic [N_INT-1:0] int_set_r;
  logic isr_r;
  logic next_r;
  logic wr_stop;
  logic wr_osc;
  logic stop_req;
  logic stop_skip;
  logic stop_exit;
  logic idle_exit;
  logic [WU_W-1:0] wu_load;

  function automatic logic [WU_W-1:0] warmup_clks(input logic [1:0] sel, input logic dbl);
    logic [WU_W-1:0] base;
    base = WU_W'(WARMUP_SHORT); // reserved code falls back to the shortest
    case (sel)
      WU_LONG: base = WU_W'(WARMUP_LONG);
      WU_MID: base = WU_W'(WARMUP_MID);
      WU_SHORT: base = WU_W'(WARMUP_SHORT);
      default: base = WU_W'(WARMUP_SHORT);
    endcase
    return dbl ? (base << 1) : base;
  endfunction : warmup_clks

  timing_gen u_timing (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tg(sif.timing)
  );

  wake_detect #(.N_INT(N_INT)) u_wake (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_stop_pin(i_stop_pin),
    .i_ext_int(i_ext_int),
    .w(sif.wake_side)
  );

  // writes are only taken while the CPU runs
  assign wr_stop = i_reg_wr && (state_r == ST_NORMAL) && (i_reg_addr == ADDR_STOP_CTRL);
  assign wr_osc = i_reg_wr && (state_r == ST_NORMAL) && (i_reg_addr == ADDR_OSC_CTRL);
  assign stop_req = wr_stop && i_reg_wdata[STOP_BIT];
  // a skipping write supplies its own method bit and warm-up code, the register is not yet loaded
  assign stop_skip = stop_req && i_reg_wdata[WAKE_METHOD_BIT] && sif.pin_high;
  assign stop_exit = (state_r == ST_WARMUP) && (wu_cnt_r == WU_DONE);
  assign idle_exit = (state_r == ST_IDLE) && i_irq_wake;
  assign wu_load = warmup_clks(stop_skip ? i_reg_wdata[WARMUP_HI:WARMUP_LO] : stop_ctrl_r[WARMUP_HI:WARMUP_LO],
    i_divider_input_select);
  assign sif.wake_method = stop_ctrl_r[WAKE_METHOD_BIT];
  // hold the generator at zero through STOP and on both edges of it
  assign sif.tg_clear = stop_req || (state_r == ST_STOP) || stop_exit || soft_rst_r;

  // clearing the oscillator enable raises soft_rst_r on the next edge; mode, registers, warm-up count and timing generator clear one edge later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_osc && !i_reg_wdata[OSC_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_NORMAL;
    end else if (soft_rst_r) begin
      state_r <= ST_NORMAL;
    end else begin
      case (state_r)
        ST_NORMAL: begin
          if (stop_skip) begin
            state_r <= ST_WARMUP;
          end else if (stop_req) begin
            state_r <= ST_STOP;
          end else if (wr_osc && i_reg_wdata[IDLE_BIT]) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (i_irq_wake) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_STOP: begin
          if (sif.wake) begin
            state_r <= ST_WARMUP;
          end
        end
        ST_WARMUP: begin
          if (stop_exit) begin
            state_r <= ST_NORMAL;
          end
        end
        default: state_r <= ST_NORMAL;
      endcase
    end
  end

  // warm-up down counter, loaded when the wake condition is seen or a level write skips STOP
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wu_cnt_r <= '0;
    end else if (soft_rst_r) begin
      wu_cnt_r <= '0;
    end else if ((state_r == ST_STOP && sif.wake) || stop_skip) begin
      wu_cnt_r <= wu_load;
    end else if (state_r == ST_WARMUP && wu_cnt_r != '0) begin
      wu_cnt_r <= wu_cnt_r - WU_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stop_ctrl_r <= STOP_CTRL_RST;
    end else if (soft_rst_r) begin
      stop_ctrl_r <= STOP_CTRL_RST;
    end else if (stop_exit) begin
      stop_ctrl_r[STOP_BIT] <= 1'b0;
    end else if (wr_stop) begin
      stop_ctrl_r <= i_reg_wdata & STOP_CTRL_RMASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_ctrl_r <= OSC_CTRL_RST;
    end else if (soft_rst_r) begin
      osc_ctrl_r <= OSC_CTRL_RST;
    end else if (stop_exit) begin
      // reserved return mode follows its table row; software keeps it at 0
      osc_ctrl_r[OSC_EN_BIT] <= (stop_ctrl_r[RETURN_MODE_BIT] == RETURN_NORMAL);
      osc_ctrl_r[MAIN_CLK_SEL_BIT] <= (stop_ctrl_r[RETURN_MODE_BIT] != RETURN_NORMAL);
    end else if (idle_exit) begin
      osc_ctrl_r[IDLE_BIT] <= 1'b0;
    end else if (wr_osc) begin
      osc_ctrl_r <= i_reg_wdata & OSC_CTRL_RMASK;
    end
  end

  // undefined bits are returned as zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_STOP_CTRL: rdata_r <= stop_ctrl_r & STOP_CTRL_RMASK;
        ADDR_OSC_CTRL: rdata_r <= osc_ctrl_r & OSC_CTRL_RMASK;
        default: rdata_r <= '0;
      endcase
    end
  end

  // pin changes during STOP or warm-up become pending latch sets
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_set_r <= '0;
    end else begin
      int_set_r <= (state_r == ST_STOP || state_r == ST_WARMUP) ? sif.int_change : '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      isr_r <= 1'b0;
      next_r <= 1'b0;
    end else begin
      isr_r <= idle_exit && i_master_interrupt_flag;
      next_r <= idle_exit && !i_master_interrupt_flag;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_mcycle_stb = sif.mc_stb;
  assign o_timebase = sif.div_q;
  assign o_mode = state_r;
  assign o_osc_enable = (state_r != ST_STOP) && osc_ctrl_r[OSC_EN_BIT];
  assign o_main_clock_select = osc_ctrl_r[MAIN_CLK_SEL_BIT];
  // a held CPU keeps its program counter at the instruction after the request
  assign o_cpu_run = (state_r == ST_NORMAL);
  assign o_wdt_run = (state_r == ST_NORMAL);
  assign o_periph_run = (state_r == ST_NORMAL) || (state_r == ST_IDLE);
  assign o_port_hiz = (state_r == ST_STOP || state_r == ST_WARMUP) && !stop_ctrl_r[PORT_HOLD_BIT];
  assign o_sys_reset = soft_rst_r;
  assign o_ext_int_set = int_set_r;
  assign o_wake_to_isr = isr_r;
  assign o_wake_to_next = next_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_STOP_ENTER: assert property ((state_r == ST_NORMAL) && stop_req && !stop_skip && !soft_rst_r
    |=> state_r == ST_STOP) else $error("stop request did not enter stop");
  AST_STOP_HALTED: assert property (state_r == ST_STOP
    |-> !o_osc_enable && !o_cpu_run && !o_periph_run && !o_wdt_run) else $error("circuits run in stop");
  AST_LEVEL_SKIP: assert property (stop_skip && !soft_rst_r
    |=> state_r == ST_WARMUP && wu_cnt_r == $past(wu_load)) else $error("level skip failed");
  AST_EDGE_WAKE: assert property ((state_r == ST_STOP) && !sif.wake_method && $rose(sif.pin_high)
    |=> state_r == ST_WARMUP) else $error("rising edge did not wake");
  AST_RETURN_NORMAL: assert property (stop_exit && !stop_ctrl_r[RETURN_MODE_BIT] && !soft_rst_r
    |=> state_r == ST_NORMAL && osc_ctrl_r[OSC_EN_BIT] && !osc_ctrl_r[MAIN_CLK_SEL_BIT] && !stop_ctrl_r[STOP_BIT])
    else $error("stop exit did not restore normal clocking");
  AST_PORT_FLOAT: assert property ((state_r == ST_STOP)
    |-> o_port_hiz == !stop_ctrl_r[PORT_HOLD_BIT]) else $error("port state wrong in stop");
  AST_IDLE_RUN: assert property (state_r == ST_IDLE
    |-> !o_cpu_run && !o_wdt_run && o_periph_run) else $error("idle gating wrong");
  AST_IDLE_EXIT: assert property (idle_exit && !soft_rst_r
    |=> state_r == ST_NORMAL && o_wake_to_isr == $past(i_master_interrupt_flag) && o_wake_to_next != o_wake_to_isr)
    else $error("idle exit wrong");
  AST_EXT_LATCH: assert property ((state_r == ST_STOP || state_r == ST_WARMUP) && (sif.int_change != '0)
    |=> o_ext_int_set == $past(sif.int_change)) else $error("pin change lost during warm-up");
  AST_OSC_RESET: assert property (wr_osc && !i_reg_wdata[OSC_EN_BIT]
    |=> o_sys_reset ##1 (state_r == ST_NORMAL) && osc_ctrl_r == OSC_CTRL_RST) else $error("oscillator clear did not reset");
  AST_WARMUP_IDLE: assert property ((state_r == ST_WARMUP)
    |-> o_osc_enable == osc_ctrl_r[OSC_EN_BIT] && !o_cpu_run && !o_periph_run) else $error("circuits run in warm-up");
  AST_STOP_BIT_CLEAR: assert property (stop_exit
    |=> !stop_ctrl_r[STOP_BIT]) else $error("stop bit not cleared on exit");
  AST_TG_HELD: assert property ((state_r == ST_STOP)
    |-> o_timebase == '0 && !o_mcycle_stb) else $error("timing generator runs in stop");
  AST_EXIT_TG_ZERO: assert property (stop_exit
    |=> o_timebase == '0) else $error("timing generator not cleared on stop exit");
  AST_WARMUP_LOAD: assert property ((state_r == ST_STOP) && sif.wake
    |=> state_r == ST_WARMUP && wu_cnt_r == $past(wu_load)) else $error("warm-up count not loaded on wake");
  AST_IDLE_BIT_CLEAR: assert property (idle_exit
    |=> !osc_ctrl_r[IDLE_BIT]) else $error("idle bit not cleared on idle exit");
endmodule : standby_clock_mode_control

// ===== verilog/standby_pkg.sv
// constants, field positions and types of the standby and clock control block
package standby_pkg;
  // register offsets on the core's register port
  localparam logic [7:0] ADDR_STOP_CTRL = 8'h38;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h39;
  // standby_stop_control fields
  localparam int STOP_BIT = 7;
  localparam int WAKE_METHOD_BIT = 6;
  localparam int RETURN_MODE_BIT = 5;
  localparam int PORT_HOLD_BIT = 4;
  localparam int WARMUP_HI = 3;
  localparam int WARMUP_LO = 2;
  // oscillator_idle_control fields
  localparam int OSC_EN_BIT = 7;
  localparam int MAIN_CLK_SEL_BIT = 5;
  localparam int IDLE_BIT = 4;
  // reset values
  localparam logic [7:0] STOP_CTRL_RST = 8'h00;
  localparam logic [7:0] OSC_CTRL_RST = 8'h80;
  // read masks: undefined and must-write-zero bits read as zero here
  localparam logic [7:0] STOP_CTRL_RMASK = 8'hFC;
  localparam logic [7:0] OSC_CTRL_RMASK = 8'hB0;
  // warm-up length codes
  localparam logic [1:0] WU_LONG = 2'h0;
  localparam logic [1:0] WU_MID = 2'h1;
  localparam logic [1:0] WU_SHORT = 2'h2;
  // return mode values
  localparam logic RETURN_NORMAL = 1'b0;
  // timing generator shape
  localparam int PRESCALE_STAGES = 3;
  localparam int DIVIDER_STAGES = 21;
  localparam int DIV_W = PRESCALE_STAGES + DIVIDER_STAGES;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MCYCLE_FC_PERIODS = 4;
  localparam int MCYCLE_W = $clog2(MCYCLE_FC_PERIODS);
  localparam logic [MCYCLE_W-1:0] MCYCLE_LAST = MCYCLE_W'(MCYCLE_FC_PERIODS - 1);
  // warm-up counter width, holds the doubled longest count
  localparam int WU_W = 19;
  localparam logic [WU_W-1:0] WU_DONE = 19'h0_0001;
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_STOP = 4'b0100,
    ST_WARMUP = 4'b1000
  } mode_t;
endpackage : standby_pkg

// ===== verilog/standby_if.sv
// signals between the mode controller, the timing generator and the wake detector
`timescale 1ns/10ps
interface standby_if #(parameter int N_INT = 6);
  import standby_pkg::*;
  logic tg_clear;
  logic mc_stb;
  logic [DIV_W-1:0] div_q;
  logic wake_method;
  logic pin_high;
  logic wake;
  logic [N_INT-1:0] int_change;
  modport timing (input tg_clear, output mc_stb, div_q);
  modport wake_side (input wake_method, output pin_high, wake, int_change);
  modport ctrl (output tg_clear, wake_method, input mc_stb, div_q, pin_high, wake, int_change);
endinterface : standby_if

// ===== verilog/timing_gen.sv
// prescaler, divider chain and machine cycle counter
`timescale 1ns/10ps
module timing_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // controller side
  standby_if.timing tg
);
  import standby_pkg::*;

  logic [DIV_W-1:0] div_r;
  logic [MCYCLE_W-1:0] mc_r;
  logic mc_stb_r;

  // prescaler stages are the low bits, the divider stages the rest
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= '0;
    end else if (tg.tg_clear) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // one machine cycle is four fc periods
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mc_r <= '0;
      mc_stb_r <= 1'b0;
    end else if (tg.tg_clear) begin
      mc_r <= '0;
      mc_stb_r <= 1'b0;
    end else begin
      mc_r <= mc_r + MCYCLE_W'(1);
      mc_stb_r <= (mc_r == MCYCLE_LAST);
    end
  end

  assign tg.div_q = div_r;
  assign tg.mc_stb = mc_stb_r;

  AST_MCYCLE_SPACING: assert property (@(posedge i_clk) disable iff (i_rst)
    (mc_stb_r && !tg.tg_clear) |=> (!mc_stb_r) [*3]) else $error("machine cycle strobe too close");
  AST_TG_CLEARED: assert property (@(posedge i_clk) disable iff (i_rst)
    tg.tg_clear |=> (div_r == '0) && !mc_stb_r) else $error("timing generator not cleared");
endmodule : timing_gen

// ===== verilog/wake_detect.sv
// wake pin and external interrupt pin synchronisers with level and edge detection
`timescale 1ns/10ps
module wake_detect #(
  parameter int N_INT = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pins
  input wire logic i_stop_pin,
  input wire logic [N_INT-1:0] i_ext_int,
  // controller side
  standby_if.wake_side w
);
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_prev_r;
  logic [N_INT-1:0] int_s1_r;
  logic [N_INT-1:0] int_s2_r;
  logic [N_INT-1:0] int_prev_r;

  // runs on the always-on clock, so it keeps watching while the oscillator is off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= i_stop_pin;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_s1_r <= '0;
      int_s2_r <= '0;
      int_prev_r <= '0;
    end else begin
      int_s1_r <= i_ext_int;
      int_s2_r <= int_s1_r;
      int_prev_r <= int_s2_r;
    end
  end

  assign w.pin_high = pin_s2_r;
  // method 1 wakes on high level, method 0 on a rising edge
  assign w.wake = w.wake_method ? pin_s2_r : (pin_s2_r & ~pin_prev_r);
  assign w.int_change = int_s2_r ^ int_prev_r;
endmodule : wake_detect

// ===== testbench/wake_pin_model.sv
// far-side model: wake pin with programmable lag and external interrupt pins
`timescale 1ns/10ps
module wake_pin_model (
  // clock
  input wire logic i_clk,
  // commands from the bench
  input wire logic i_level,
  input wire logic [7:0] i_lag,
  input wire logic [5:0] i_flip,
  // pins
  output logic o_stop_pin,
  output logic [5:0] o_ext_int
);
  logic [7:0] wait_r;
  initial begin
    o_stop_pin = 1'b0;
    o_ext_int = 6'h00;
    wait_r = 8'h00;
  end
  // a slow pin follows the command only after the lag has run out
  always @(posedge i_clk) begin
    if (i_level == o_stop_pin) begin
      wait_r <= 8'h00;
    end else if (wait_r >= i_lag) begin
      o_stop_pin <= i_level;
      wait_r <= 8'h00;
    end else begin
      wait_r <= wait_r + 8'h01;
    end
    o_ext_int <= o_ext_int ^ i_flip;
  end
endmodule : wake_pin_model

// ===== testbench/standby_clock_mode_control_tb.sv
// self-checking bench for the standby and clock mode controller
`timescale 1ns/10ps
module standby_clock_mode_control_tb;
  import standby_pkg::*;
  // short warm-up lengths keep the run brief
  localparam int WL = 12;
  localparam int WM = 8;
  localparam int WS = 4;
  localparam int LIMIT = 6000;
  logic i_clk, i_rst, wr, rd, dsel, irq, master_interrupt_flag, pin_lvl, stop_pin, stb;
  logic osc_en, clk_sel, cpu_run, wdt_run, per_run, hiz, sys_rst, to_isr, to_next;
  logic seen_rst, seen_isr, seen_next;
  logic [7:0] addr, wdata, rdata, lag, v;
  logic [5:0] flip, ext_int, int_set, seen_int;
  logic [23:0] tbase, t;
  logic [3:0] mode;
  logic [1:0] c;
  int err_count, total_checks, cyc, n, e;

  wake_pin_model u_pin (.i_clk(i_clk), .i_level(pin_lvl), .i_lag(lag), .i_flip(flip),
    .o_stop_pin(stop_pin), .o_ext_int(ext_int));
  standby_clock_mode_control #(.N_INT(6), .WARMUP_LONG(WL), .WARMUP_MID(WM), .WARMUP_SHORT(WS)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_stop_pin(stop_pin), .i_ext_int(ext_int),
    .i_divider_input_select(dsel), .i_irq_wake(irq), .i_master_interrupt_flag(master_interrupt_flag),
    .o_mcycle_stb(stb), .o_timebase(tbase), .o_mode(mode), .o_osc_enable(osc_en),
    .o_main_clock_select(clk_sel), .o_cpu_run(cpu_run), .o_wdt_run(wdt_run), .o_periph_run(per_run),
    .o_port_hiz(hiz), .o_sys_reset(sys_rst), .o_ext_int_set(int_set), .o_wake_to_isr(to_isr),
    .o_wake_to_next(to_next));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // one-cycle pulses are caught here so the sequence may look later
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (sys_rst === 1'b1) seen_rst <= 1'b1;
    if (to_isr === 1'b1) seen_isr <= 1'b1;
    if (to_next === 1'b1) seen_next <= 1'b1;
    seen_int <= seen_int | int_set;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    tick(1);
    d = rdata;
  endtask : rreg

  task automatic waitmode(input logic [3:0] m);
    n = 0;
    while (mode !== m && n < 200) begin
      tick(1);
      n++;
    end
  endtask : waitmode

  // counts the cycles spent in warm-up
  task automatic wu(input int exp);
    n = 0;
    while (mode === ST_WARMUP && n < 100) begin
      n++;
      tick(1);
    end
    check(24'(n), 24'(exp));
  endtask : wu

  task automatic results;
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    {i_rst, wr, rd, dsel, irq, master_interrupt_flag, pin_lvl} = 7'b1000000;
    {addr, wdata, lag, flip} = 30'h0;
    {seen_rst, seen_isr, seen_next, seen_int} = 9'h0;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    check(mode, ST_NORMAL);
    check({osc_en, clk_sel, cpu_run, wdt_run, per_run, hiz}, 24'h2E);
    rreg(ADDR_STOP_CTRL, v);
    check(v, STOP_CTRL_RST);
    rreg(ADDR_OSC_CTRL, v);
    check(v, OSC_CTRL_RST);
    rreg(8'h3A, v);
    check(v, 8'h00);
    // align to a strobe first, then count to the next one
    n = 0;
    while (stb !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (stb !== 1'b1 && n < 8);
    check(24'(n), 24'(MCYCLE_FC_PERIODS));
    t = tbase;
    tick(1);
    check(tbase, t + 24'h1);
    // undefined bits read back as zero; bit 6 of the oscillator register written as zero
    wreg(ADDR_STOP_CTRL, 8'h1F);
    rreg(ADDR_STOP_CTRL, v);
    check(v, 8'h1C);
    wreg(ADDR_OSC_CTRL, 8'h8F);
    rreg(ADDR_OSC_CTRL, v);
    check(v, 8'h80);
    // edge wake: a pin already high must not wake, port outputs held
    pin_lvl = 1'b1;
    tick(4);
    wreg(ADDR_STOP_CTRL, 8'h98);
    check(mode, ST_STOP);
    check({osc_en, cpu_run, hiz}, 24'h0);
    check(tbase, 24'h0);
    @(posedge i_clk);
    flip <= 6'h04;
    @(posedge i_clk);
    flip <= 6'h00;
    tick(10);
    check(mode, ST_STOP);
    check(seen_int, 6'h04);
    lag = 8'd20;
    pin_lvl = 1'b0;
    tick(30);
    pin_lvl = 1'b1;
    waitmode(ST_WARMUP);
    check(mode, ST_WARMUP);
    check(osc_en, 1'b1);
    wu(WS);
    check(mode, ST_NORMAL);
    check({osc_en, clk_sel}, 24'h2);
    rreg(ADDR_STOP_CTRL, v);
    check(v, 8'h18);
    // level method with pin high skips STOP; every warm-up code, both divider selects
    lag = 8'd0;
    for (int k = 0; k < 8; k++) begin
      c = k[1:0];
      @(posedge i_clk);
      dsel <= k[2];
      wreg(ADDR_STOP_CTRL, {4'hC, c, 2'b00});
      check(mode, ST_WARMUP);
      check(hiz, 1'b1);
      e = (c == 2'd0) ? WL : (c == 2'd1) ? WM : WS;
      wu(k[2] ? 2 * e : e);
    end
    // level wake from a real stop
    pin_lvl = 1'b0;
    tick(5);
    wreg(ADDR_STOP_CTRL, 8'hD4);
    check(mode, ST_STOP);
    pin_lvl = 1'b1;
    waitmode(ST_WARMUP);
    check(mode, ST_WARMUP);
    wu(2 * WM);
    // reset pin ends STOP in NORMAL
    pin_lvl = 1'b0;
    tick(5);
    wreg(ADDR_STOP_CTRL, 8'h90);
    check(mode, ST_STOP);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    check(mode, ST_NORMAL);
    rreg(ADDR_STOP_CTRL, v);
    check(v, 8'h00);
    // idle exit through the service path and the next-instruction path
    for (int m = 1; m >= 0; m--) begin
      {seen_isr, seen_next} = 2'b00;
      @(posedge i_clk);
      master_interrupt_flag <= m[0];
      wreg(ADDR_OSC_CTRL, 8'h90);
      check(mode, ST_IDLE);
      check({cpu_run, wdt_run, per_run}, 24'h1);
      tick(5);
      @(posedge i_clk);
      irq <= 1'b1;
      @(posedge i_clk);
      irq <= 1'b0;
      tick(2);
      check(mode, ST_NORMAL);
      check({seen_isr, seen_next}, {m[0], ~m[0]});
    end
    // clearing the oscillator enable resets the device
    wreg(ADDR_STOP_CTRL, 8'h1C);
    wreg(ADDR_OSC_CTRL, 8'h00);
    tick(3);
    check(seen_rst, 1'b1);
    rreg(ADDR_OSC_CTRL, v);
    check(v, 8'h80);
    rreg(ADDR_STOP_CTRL, v);
    check(v, 8'h00);
    results();
  end
endmodule : standby_clock_mode_control_tb
